// [rtl/bfsup_top.sv]
// breaker failure supervision: trigger select, supervision timer, backup trip, lockout
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module bfsup_top
  import bfsup_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              wbCyc,
  input  wire logic              wbStb,
  input  wire logic              wbWe,
  input  wire logic [ADR_W-1:0]  wbAdr,
  input  wire logic [3:0]        wbSel,
  input  wire logic [31:0]       wbDatIn,
  output logic      [31:0]       wbDatOut,
  output logic                   wbAck,
  input  wire bfsup_trips_t      trips,
  input  wire logic [NEXTRA-1:0] extraTrigger,
  input  wire logic [CUR_W-1:0]  measCurrent,
  input  wire logic              posOpenPin,
  input  wire logic [1:0]        activeSet,
  output logic                   backupTrip,
  output logic                   lockout,
  output bfsup_state_t           monState
);

  bfsup_cfg_t       cfg_ff;
  logic [CUR_W-1:0] thr_ff [NSETS];
  logic [DLY_W-1:0] dly_ff [NSETS];
  bfsup_state_t     state_ff, nxt_state;
  logic [DLY_W-1:0] cnt_ff;
  logic             trip_ff;
  logic             lock_ff;
  logic             posMeta_ff, posOpen_ff;
  logic             ack_ff;
  logic [31:0]      rdat_ff;
  logic [31:0]      rdVal;

  logic             busReq, busWr;
  logic             ackWr;
  logic             trigAssigned, trigger;
  logic             currentAbove, confirmed, expire;
  logic [CUR_W-1:0] actThr;
  logic [DLY_W-1:0] actDly;

  // ---------------- bus slave ----------------
  // single-wait answer: ack one cycle after the request, dropped the cycle after
  assign busReq = wbCyc & wbStb & ~ack_ff;
  assign busWr  = busReq & wbWe;
  assign wbAck  = ack_ff;
  assign wbDatOut = rdat_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else if (ce) begin
      ack_ff <= busReq;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ff <= CFG_RST;
    end else if (ce && busWr && wbAdr == CFG_OFS && wbSel[0]) begin
      cfg_ff <= bfsup_cfg_t'(wbDatIn[CFG_SCHEME_LSB +: $bits(bfsup_cfg_t)]);
    end
  end

  // one threshold and one delay per parameter set
  for (genvar s = 0; s < NSETS; s++) begin : g_set
    localparam logic [ADR_W-1:0] THR_A = THR_BASE + ADR_W'(s << IDX_LSB);
    localparam logic [ADR_W-1:0] DLY_A = DLY_BASE + ADR_W'(s << IDX_LSB);
    always_ff @(posedge clock) begin
      if (rst) begin
        thr_ff[s] <= THR_RST;
        dly_ff[s] <= DLY_RST;
      end else if (ce && busWr) begin
        if (wbAdr == THR_A) begin
          if (wbSel[0]) thr_ff[s][7:0]  <= wbDatIn[7:0];
          if (wbSel[1]) thr_ff[s][15:8] <= wbDatIn[15:8];
        end
        if (wbAdr == DLY_A) begin
          if (wbSel[0]) dly_ff[s][7:0]   <= wbDatIn[7:0];
          if (wbSel[1]) dly_ff[s][15:8]  <= wbDatIn[15:8];
          if (wbSel[2]) dly_ff[s][23:16] <= wbDatIn[23:16];
        end
      end
    end
  end

  assign ackWr = ce & busWr & (wbAdr == ACK_OFS) & wbSel[0] & wbDatIn[ACK_BIT];

  always_comb begin
    rdVal = 32'h0000_0000;
    if (wbAdr == CFG_OFS) begin
      rdVal[CFG_SCHEME_LSB +: $bits(bfsup_cfg_t)] = cfg_ff;
    end else if (wbAdr == STAT_OFS) begin
      rdVal[ST_STATE_LSB +: 2] = state_ff;
      rdVal[ST_TRIP_BIT]       = trip_ff;
      rdVal[ST_LOCK_BIT]       = lock_ff;
      rdVal[ST_OPEN_BIT]       = posOpen_ff;
      rdVal[ST_ABOVE_BIT]      = currentAbove;
      rdVal[ST_TRIG_BIT]       = trigger;
      rdVal[ST_SET_LSB +: 2]   = activeSet;
    end else if ((wbAdr & SET_MASK) == THR_BASE) begin
      rdVal[CUR_W-1:0] = thr_ff[wbAdr[IDX_LSB +: 2]];
    end else if ((wbAdr & SET_MASK) == DLY_BASE) begin
      rdVal[DLY_W-1:0] = dly_ff[wbAdr[IDX_LSB +: 2]];
    end
  end

  // unmapped and write-only addresses read as zero, except unaligned offsets in 0x10-0x2F, which alias a set register
  always_ff @(posedge clock) begin
    if (rst) begin
      rdat_ff <= 32'h0000_0000;
    end else if (ce && busReq) begin
      rdat_ff <= rdVal;
    end
  end

  // ---------------- position input ----------------
  always_ff @(posedge clock) begin
    if (rst) begin
      posMeta_ff <= 1'b0;
      posOpen_ff <= 1'b0;
    end else if (ce) begin
      posMeta_ff <= posOpenPin;
      posOpen_ff <= posMeta_ff;
    end
  end

  // ---------------- supervision ----------------
  assign actThr = thr_ff[activeSet];
  assign actDly = (dly_ff[activeSet] == '0) ? DLY_ONE : dly_ff[activeSet];
  assign currentAbove = measCurrent >= actThr;

  always_comb begin
    case (cfg_ff.trigMode)
      TM_ALL:  trigAssigned = trips.allTrips;
      TM_EXT:  trigAssigned = trips.extTrips;
      TM_CUR:  trigAssigned = trips.curTrips;
      TM_NONE: trigAssigned = 1'b0;
      default: trigAssigned = 1'b0;
    endcase
  end
  assign trigger = trigAssigned | (|(extraTrigger & cfg_ff.extraEn));

  // a confirmed opening beats expiry in the same cycle
  always_comb begin
    case (cfg_ff.scheme)
      SCH_CURRENT:  confirmed = ~currentAbove;
      SCH_POSITION: confirmed = posOpen_ff;
      SCH_COMBINED: confirmed = ~currentAbove | posOpen_ff;
      default:      confirmed = ~currentAbove;
    endcase
  end
  assign expire = (cnt_ff + DLY_ONE) >= actDly;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STANDBY: if (trigger) nxt_state = ST_RUNNING;
      ST_RUNNING: begin
        if (confirmed) nxt_state = trigger ? ST_REJECTED : ST_STANDBY;
        else if (expire) nxt_state = ST_FAILED;
      end
      ST_REJECTED: if (!trigger) nxt_state = ST_STANDBY;
      ST_FAILED:   if (!trigger) nxt_state = ST_STANDBY;
      default:     nxt_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ST_STANDBY;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= (nxt_state == ST_RUNNING && state_ff == ST_RUNNING) ? cnt_ff + DLY_ONE : '0;
    end
  end

  // trip follows the failed state so the upstream breaker is held while triggers persist
  always_ff @(posedge clock) begin
    if (rst) begin
      trip_ff <= 1'b0;
    end else if (ce) begin
      trip_ff <= (nxt_state == ST_FAILED);
    end
  end

  // new failure wins over an acknowledge in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      lock_ff <= 1'b0;
    end else if (ce) begin
      if (nxt_state == ST_FAILED && state_ff != ST_FAILED) lock_ff <= 1'b1;
      else if (ackWr) lock_ff <= 1'b0;
    end
  end

  assign backupTrip = trip_ff;
  assign lockout    = lock_ff;
  assign monState   = state_ff;

  // ---------------- assertions ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_lock_with_trip;
    $rose(trip_ff) |-> lock_ff;
  endproperty
  a_lock_with_trip: assert property (p_lock_with_trip) else $error("lockout late");

  property p_lock_hold;
    lock_ff && !(ce && busWr && wbAdr == ACK_OFS && wbDatIn[ACK_BIT] && wbSel[0]) |=> lock_ff;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout lost");

  property p_reset_state;
    $past(rst) |-> state_ff == ST_STANDBY && !trip_ff && !lock_ff && cnt_ff == '0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset");

  property p_keep_running;
    state_ff == ST_RUNNING && ce && !confirmed && !expire |=> state_ff == ST_RUNNING;
  endproperty
  a_keep_running: assert property (p_keep_running) else $error("timer stopped");

  property p_expire_trip;
    state_ff == ST_RUNNING && ce && expire && !confirmed |=> trip_ff && lock_ff;
  endproperty
  a_expire_trip: assert property (p_expire_trip) else $error("no trip");

  property p_reject;
    state_ff == ST_RUNNING && ce && confirmed && trigger |=> state_ff == ST_REJECTED;
  endproperty
  a_reject: assert property (p_reject) else $error("no reject");

  property p_reject_hold;
    state_ff == ST_REJECTED && (trigger || !ce) |=> state_ff == ST_REJECTED;
  endproperty
  a_reject_hold: assert property (p_reject_hold) else $error("left reject");

  property p_standby_back;
    state_ff == ST_REJECTED && ce && !trigger |=> state_ff == ST_STANDBY;
  endproperty
  a_standby_back: assert property (p_standby_back) else $error("no standby");

  property p_current_fail;
    state_ff == ST_RUNNING && ce && cfg_ff.scheme == SCH_CURRENT && !currentAbove
      |=> state_ff != ST_FAILED;
  endproperty
  a_current_fail: assert property (p_current_fail) else $error("false fail");

  property p_combined_fail;
    state_ff == ST_RUNNING && ce && cfg_ff.scheme == SCH_COMBINED && posOpen_ff
      |=> !$rose(trip_ff);
  endproperty
  a_combined_fail: assert property (p_combined_fail) else $error("false combined");

  property p_no_assign;
    state_ff == ST_STANDBY && ce && cfg_ff.trigMode == TM_NONE && cfg_ff.extraEn == '0
      |=> state_ff == ST_STANDBY;
  endproperty
  a_no_assign: assert property (p_no_assign) else $error("bad start");

  property p_position_fail;
    state_ff == ST_RUNNING && ce && cfg_ff.scheme == SCH_POSITION && posOpen_ff
      |=> state_ff != ST_FAILED;
  endproperty
  a_position_fail: assert property (p_position_fail) else $error("false open");

  property p_start;
    state_ff == ST_STANDBY && ce && trigger |=> state_ff == ST_RUNNING;
  endproperty
  a_start: assert property (p_start) else $error("no start");

  property p_trip_state;
    trip_ff == (state_ff == ST_FAILED);
  endproperty
  a_trip_state: assert property (p_trip_state) else $error("trip off state");

  property p_lock_clear;
    lock_ff && ackWr && !(nxt_state == ST_FAILED && state_ff != ST_FAILED) |=> !lock_ff;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("ack ignored");

  property p_count_step;
    state_ff == ST_RUNNING && ce && nxt_state == ST_RUNNING
      |=> cnt_ff == $past(cnt_ff) + DLY_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("timer stalled");

  property p_ext_mode;
    state_ff == ST_STANDBY && ce && cfg_ff.trigMode == TM_EXT && !trips.extTrips
      && (extraTrigger & cfg_ff.extraEn) == '0 |=> state_ff == ST_STANDBY;
  endproperty
  a_ext_mode: assert property (p_ext_mode) else $error("foreign start");

  property p_cur_mode;
    state_ff == ST_STANDBY && ce && cfg_ff.trigMode == TM_CUR && !trips.curTrips
      && (extraTrigger & cfg_ff.extraEn) == '0 |=> state_ff == ST_STANDBY;
  endproperty
  a_cur_mode: assert property (p_cur_mode) else $error("non current start");

  property p_set_delay;
    state_ff == ST_RUNNING && ce && !confirmed && cnt_ff + DLY_ONE < dly_ff[activeSet]
      |=> state_ff == ST_RUNNING;
  endproperty
  a_set_delay: assert property (p_set_delay) else $error("early expiry");

  c_fail:   cover property (state_ff == ST_RUNNING ##1 state_ff == ST_FAILED);
  c_reject: cover property (state_ff == ST_RUNNING ##1 state_ff == ST_REJECTED);
  c_ack:    cover property (lock_ff ##1 !lock_ff);
  c_position: cover property (cfg_ff.scheme == SCH_POSITION && state_ff == ST_FAILED);
  c_extra:    cover property (state_ff == ST_STANDBY && trigger && !trigAssigned);

endmodule : bfsup_top

// [rtl/bfsup_pkg.sv]
// shared constants, types and register map of the breaker failure supervision block
package bfsup_pkg;

  localparam int CUR_W   = 16;
  localparam int DLY_W   = 24;
  localparam int NSETS   = 4;
  localparam int NEXTRA  = 3;
  localparam int ADR_W   = 8;

  // register byte offsets
  localparam logic [ADR_W-1:0] CFG_OFS   = 8'h00;
  localparam logic [ADR_W-1:0] STAT_OFS  = 8'h04;
  localparam logic [ADR_W-1:0] ACK_OFS   = 8'h08;
  localparam logic [ADR_W-1:0] THR_BASE  = 8'h10;
  localparam logic [ADR_W-1:0] DLY_BASE  = 8'h20;
  localparam logic [ADR_W-1:0] SET_MASK  = 8'hF0;
  localparam int               IDX_LSB   = 2;

  // configuration field positions
  localparam int CFG_SCHEME_LSB = 0;
  localparam int CFG_TMODE_LSB  = 2;
  localparam int CFG_EXTRA_LSB  = 4;
  localparam int ACK_BIT        = 0;

  // status field positions
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_TRIP_BIT   = 2;
  localparam int ST_LOCK_BIT   = 3;
  localparam int ST_OPEN_BIT   = 4;
  localparam int ST_ABOVE_BIT  = 5;
  localparam int ST_TRIG_BIT   = 6;
  localparam int ST_SET_LSB    = 8;

  typedef enum logic [1:0] {
    SCH_CURRENT  = 2'h0,
    SCH_POSITION = 2'h1,
    SCH_COMBINED = 2'h2
  } bfsup_scheme_t;

  typedef enum logic [1:0] {
    TM_ALL  = 2'h0,
    TM_EXT  = 2'h1,
    TM_CUR  = 2'h2,
    TM_NONE = 2'h3
  } bfsup_tmode_t;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_RUNNING,
    ST_REJECTED,
    ST_FAILED
  } bfsup_state_t;

  typedef struct packed {
    logic [NEXTRA-1:0] extraEn;
    bfsup_tmode_t      trigMode;
    bfsup_scheme_t     scheme;
  } bfsup_cfg_t;

  // trip commands assigned to the monitored breaker, by origin
  typedef struct packed {
    logic allTrips;
    logic extTrips;
    logic curTrips;
  } bfsup_trips_t;

  localparam bfsup_cfg_t       CFG_RST = '{extraEn: 3'h0, trigMode: TM_ALL,
                                           scheme: SCH_CURRENT};
  localparam logic [CUR_W-1:0] THR_RST = 16'h0100;
  localparam logic [DLY_W-1:0] DLY_RST = 24'h00C350;
  localparam logic [DLY_W-1:0] DLY_ONE = 24'h000001;

endpackage : bfsup_pkg

// [tb/bfsup_partner.sv]
// behavioural model of the trip manager, current measurement and breaker position
`timescale 1ns/1ps
module bfsup_partner
  import bfsup_pkg::*;
(
  input  wire logic              curFlow,
  input  wire logic              brkOpen,
  input  wire bfsup_trips_t      tripCmd,
  input  wire logic [NEXTRA-1:0] extraCmd,
  output bfsup_trips_t           trips,
  output logic [NEXTRA-1:0]      extraTrigger,
  output logic [CUR_W-1:0]       measCurrent,
  output logic                   posOpenPin
);
  // only real trip commands reach the block, never supervision-only ones
  // an external or current trip is an assigned trip as well, so it also sets allTrips
  assign trips        = '{allTrips: |tripCmd, extTrips: tripCmd.extTrips,
                          curTrips: tripCmd.curTrips};
  assign extraTrigger = extraCmd;
  // a stuck current or position indicator is a commanded fault, not a default
  assign measCurrent  = curFlow ? 16'h0200 : 16'h0010;
  assign posOpenPin   = brkOpen;
endmodule : bfsup_partner

// [tb/bfsup_top_tb.sv]
// self-checking bench for the breaker failure supervision block
`timescale 1ns/1ps
module bfsup_top_tb;
  import bfsup_pkg::*;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic               wbCyc = 1'b0;
  logic               wbStb = 1'b0;
  logic               wbWe = 1'b0;
  logic [ADR_W-1:0]   wbAdr = 8'h00;
  logic [31:0]        wbDatIn = 32'h0;
  logic [31:0]        wbDatOut, rdat;
  logic               wbAck, posOpenPin, backupTrip, lockout;
  logic               curFlow = 1'b1;
  logic               brkOpen = 1'b0;
  logic [1:0]         activeSet = 2'h0;
  bfsup_trips_t       trips;
  bfsup_trips_t       tripCmd = 3'h0;
  logic [NEXTRA-1:0]  extraTrigger;
  logic [NEXTRA-1:0]  extraCmd = 3'h0;
  logic [CUR_W-1:0]   measCurrent;
  bfsup_state_t       monState;
  int                 bad_count = 0;
  int                 comparisons = 0;
  int                 dly = 5;

  always #4 clock = ~clock;

  bfsup_partner bfsup_partner_inst (.curFlow(curFlow), .brkOpen(brkOpen), .tripCmd(tripCmd),
    .extraCmd(extraCmd), .trips(trips), .extraTrigger(extraTrigger),
    .measCurrent(measCurrent), .posOpenPin(posOpenPin));
  bfsup_top bfsup_top_inst (.clock(clock), .rst(rst), .ce(1'b1), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hF), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .trips(trips), .extraTrigger(extraTrigger), .measCurrent(measCurrent),
    .posOpenPin(posOpenPin), .activeSet(activeSet), .backupTrip(backupTrip),
    .lockout(lockout), .monState(monState));

  task automatic final_report();
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatIn <= dat;
    // ack and read data are seen as they stood at the rising edge, before the design moves on
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      bad_count++;
      final_report();
    end else begin
      rdat = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
    end
  endtask : wb

  task automatic cfg(input logic [1:0] s, input logic [1:0] m, input logic [2:0] e);
    wb(1'b1, CFG_OFS, {25'h0, e, m, s});
  endtask : cfg

  task automatic clear_lock();
    check("lockout held", 32'h1, lockout);
    wb(1'b1, ACK_OFS, 32'h1);
    cyc(1);
    check("lockout cleared", 32'h0, lockout);
  endtask : clear_lock

  // trigger held, indicators as given; the outcome is judged once the timer is long over
  task automatic supervise(input logic [2:0] tc, input logic [2:0] ec, input logic cf,
                           input logic bo, input bfsup_state_t exp);
    @(posedge clock);
    tripCmd <= tc;
    extraCmd <= ec;
    curFlow <= cf;
    brkOpen <= bo;
    cyc(dly + 6);
    check("outcome", exp, monState);
    check("backup trip", exp == ST_FAILED, backupTrip);
    @(posedge clock);
    tripCmd <= 3'h0;
    extraCmd <= 3'h0;
    cyc(3);
    check("standby", ST_STANDBY, monState);
    if (exp == ST_FAILED) clear_lock();
    @(posedge clock);
    curFlow <= 1'b1;
    brkOpen <= 1'b0;
    cyc(4);
  endtask : supervise

  task automatic t_timing(input int d);
    int n;
    @(posedge clock);
    tripCmd <= 3'h4;
    @(posedge clock);
    tripCmd <= 3'h0;
    #1;
    n = 1;
    while (backupTrip !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (backupTrip !== 1'b1) begin
      bad_count++;
      final_report();
    end else begin
      check("expiry edge", d + 1, n);
      check("lockout with trip", 32'h1, lockout);
      cyc(2);
      check("drop to standby", ST_STANDBY, monState);
      check("trip released", 32'h0, backupTrip);
      clear_lock();
    end
  endtask : t_timing

  // the bus only answers once reset is released, so register reads wait for that
  task automatic t_reset(input bit bus);
    check("reset state", ST_STANDBY, monState);
    check("reset outputs", 32'h0, {backupTrip, lockout});
    if (bus) begin
      wb(1'b0, THR_BASE, 32'h0);
      check("threshold reset", THR_RST, rdat);
      wb(1'b0, DLY_BASE, 32'h0);
      check("delay reset", DLY_RST, rdat);
      wb(1'b0, 8'hFC, 32'h0);
      check("unmapped read", 32'h0, rdat);
    end
  endtask : t_reset

  task automatic t_schemes();
    bfsup_state_t tbl [3][3] = '{'{ST_REJECTED, ST_FAILED, ST_FAILED},
                                 '{ST_FAILED, ST_REJECTED, ST_FAILED},
                                 '{ST_REJECTED, ST_REJECTED, ST_FAILED}};
    for (int s = 0; s < 3; s++) begin
      cfg(2'(s), 2'h0, 3'h0);
      supervise(3'h4, 3'h0, 1'b0, 1'b0, tbl[s][0]);
      supervise(3'h4, 3'h0, 1'b1, 1'b1, tbl[s][1]);
      supervise(3'h4, 3'h0, 1'b1, 1'b0, tbl[s][2]);
    end
  endtask : t_schemes

  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      cfg(2'h0, 2'(m), 3'h0);
      supervise(3'(4 >> m), 3'h0, 1'b1, 1'b0, ST_FAILED);
    end
    cfg(2'h0, 2'h1, 3'h0);
    supervise(3'h1, 3'h0, 1'b1, 1'b0, ST_STANDBY);
    cfg(2'h0, 2'h2, 3'h0);
    supervise(3'h2, 3'h0, 1'b1, 1'b0, ST_STANDBY);
    cfg(2'h0, 2'h3, 3'h7);
    supervise(3'h7, 3'h0, 1'b1, 1'b0, ST_STANDBY);
    for (int e = 0; e < 3; e++) supervise(3'h0, 3'(1 << e), 1'b1, 1'b0, ST_FAILED);
    cfg(2'h0, 2'h3, 3'h0);
    supervise(3'h0, 3'h7, 1'b1, 1'b0, ST_STANDBY);
  endtask : t_modes

  task automatic t_sets();
    wb(1'b1, DLY_BASE + 8'h08, 32'h3);
    wb(1'b1, THR_BASE + 8'h08, 32'h0300);
    @(posedge clock);
    activeSet <= 2'h2;
    cfg(2'h1, 2'h0, 3'h0);
    t_timing(3);
    cfg(2'h0, 2'h0, 3'h0);
    supervise(3'h4, 3'h0, 1'b1, 1'b0, ST_REJECTED);
  endtask : t_sets

  initial begin
    cyc(3);
    t_reset(1'b0);
    @(posedge clock);
    rst <= 1'b0;
    cyc(1);
    t_reset(1'b1);
    // delay kept short, still longer than relay, breaker and drop-off times here
    wb(1'b1, DLY_BASE, 32'h5);
    t_timing(5);
    t_schemes();
    t_modes();
    t_sets();
    final_report();
  end
endmodule : bfsup_top_tb
